// >>> loop_code_pkg.sv
// Constants, register map and state record of the in-band loop code block
package loop_code_pkg;
  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_RX_INFO  = 6'h09;
  localparam logic [5:0] IDX_CODE_CTL = 6'h0a;
  localparam logic [5:0] IDX_TX1      = 6'h0b;
  localparam logic [5:0] IDX_TX2      = 6'h0c;
  localparam logic [5:0] IDX_UP1      = 6'h0d;
  localparam logic [5:0] IDX_UP2      = 6'h0e;
  localparam logic [5:0] IDX_DN1      = 6'h0f;
  localparam logic [5:0] IDX_DN2      = 6'h10;
  localparam logic [5:0] IDX_CTL      = 6'h11;
  localparam logic [5:0] IDX_STATUS   = 6'h12;
  localparam logic [5:0] IDX_INT_EN   = 6'h13;
  localparam logic [5:0] IDX_INT_CLR  = 6'h14;
  // Field positions
  localparam int TXLEN_LSB  = 6;
  localparam int UPLEN_LSB  = 3;
  localparam int DNLEN_LSB  = 0;
  localparam int CTL_TX_EN  = 0;
  localparam int CTL_AUTO_RLB_DETECTED   = 1;
  localparam int ST_UP      = 0;
  localparam int ST_DN      = 1;
  localparam int ST_SEC     = 2;
  localparam int LEVEL_LSB  = 4;
  // Bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Timing, counted in received line bits
  localparam int unsigned LINE_RATE_HZ = 2048000;
  localparam int unsigned INTEG_MS     = 48;
  localparam int unsigned SECOND_MS    = 1000;
  localparam int unsigned INTEG_BITS   = INTEG_MS * (LINE_RATE_HZ / 1000);
  localparam int unsigned SEC_BITS     = SECOND_MS * (LINE_RATE_HZ / 1000);
  localparam logic [2:0]  HOLD_SEC     = 3'h5;
  localparam int unsigned MISS_DIV     = 4;

  typedef enum logic [1:0] {BS_IDLE = 2'b00, BS_ACK = 2'b01, BS_RESP = 2'b11} bus_st_t;

  typedef struct packed {
    bus_st_t     wst;
    bus_st_t     rst;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic [7:0]  code_ctl;
    logic [7:0]  tx1;
    logic [7:0]  tx2;
    logic [7:0]  up1;
    logic [7:0]  up2;
    logic [7:0]  dn1;
    logic [7:0]  dn2;
    logic        tx_en;
    logic        auto_rlb_detected_en;
    logic [2:0]  status;
    logic [2:0]  int_en;
    logic        irq;
    logic [3:0]  level;
    logic        sec_flag;
    logic        auto_rlb_detected;
    logic [15:0] hist;
    logic [31:0] win_cnt;
    logic [31:0] up_miss;
    logic [31:0] dn_miss;
    logic [31:0] sec_cnt;
    logic        up_present;
    logic        dn_present;
    logic [2:0]  up_secs;
    logic [2:0]  dn_secs;
    logic [3:0]  tx_phase;
    logic        tx_data;
  } state_t;

  localparam state_t STATE_RST = '0;
endpackage : loop_code_pkg

// >>> inband_loop_code_diag.sv
// In-band loop code generator and detector with AXI4-Lite registers
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module inband_loop_code_diag
  import loop_code_pkg::*;
#(
  parameter int unsigned INTEG_LEN = INTEG_BITS,
  parameter int unsigned SEC_LEN   = SEC_BITS
)(
  input  wire logic        CLK,
  input  wire logic        RESET_N,
  input  wire logic [7:0]  AWADDR,
  input  wire logic        AWVALID,
  output wire logic        AWREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  input  wire logic        WVALID,
  output wire logic        WREADY,
  output wire logic [1:0]  BRESP,
  output wire logic        BVALID,
  input  wire logic        BREADY,
  input  wire logic [7:0]  ARADDR,
  input  wire logic        ARVALID,
  output wire logic        ARREADY,
  output wire logic [31:0] RDATA,
  output wire logic [1:0]  RRESP,
  output wire logic        RVALID,
  input  wire logic        RREADY,
  input  wire logic        RX_BIT_VALID,
  input  wire logic        RX_BIT,
  input  wire logic [3:0]  RX_LEVEL,
  input  wire logic        TX_BIT_REQ,
  output wire logic        TX_BIT,
  output wire logic        REMOTE_LOOPBACK,
  output wire logic        IRQ
);

  state_t      q;
  state_t      next_q;
  logic [5:0]  widx;
  logic [5:0]  ridx;
  logic [2:0]  clr;
  logic [2:0]  set;
  logic        sec_tick;
  logic        sec_read;
  logic        up_hit;
  logic        dn_hit;
  logic [4:0]  tx_len;
  logic [15:0] tx_code;

  function automatic logic [4:0] rx_len(input logic [2:0] f);
    return (f == 3'h7) ? 5'h10 : {2'h0, f} + 5'h1;
  endfunction : rx_len

  // Periodic code seen in the newest n bits under any phase
  function automatic logic rot_match(input logic [15:0] h, input logic [15:0] c, input logic [4:0] n);
    logic any;
    logic ok;
    int   nn;
    int   k;
    any = 1'b0;
    nn = int'(n);
    for (int r = 0; r < 16; r++)
    begin
      ok = (r < nn);
      for (int i = 0; i < 16; i++)
      begin
        k = i + r;
        if (k >= nn)
          k = k - nn;
        if (i < nn && k < 16 && h[nn - 1 - i] != c[15 - k])
          ok = 1'b0;
      end
      any = any | ok;
    end
    return any;
  endfunction : rot_match

  assign widx    = AWADDR[7:2];
  assign ridx    = ARADDR[7:2];
  assign tx_code = {q.tx1, q.tx2};

  always_comb
  begin
    next_q   = q;
    clr      = 3'h0;
    set      = 3'h0;
    sec_tick = 1'b0;
    sec_read = 1'b0;
    up_hit   = 1'b0;
    dn_hit   = 1'b0;
    // Length 3 runs as 6 and 8 as 16, so software repeats the short code
    case (q.code_ctl[TXLEN_LSB +: 2])
      2'h0:    tx_len = 5'h5;
      2'h1:    tx_len = 5'h6;
      2'h2:    tx_len = 5'h7;
      default: tx_len = 5'h10;
    endcase

    case (q.wst)
      BS_IDLE:
        if (AWVALID && WVALID)
        begin
          next_q.awready = 1'b1;
          next_q.wready  = 1'b1;
          next_q.wst     = BS_ACK;
        end
      BS_ACK:
      begin
        next_q.awready = 1'b0;
        next_q.wready  = 1'b0;
        next_q.bvalid  = 1'b1;
        next_q.bresp   = RESP_OKAY;
        next_q.wst     = BS_RESP;
        case (widx)
          IDX_CODE_CTL: if (WSTRB[0]) next_q.code_ctl = WDATA[7:0];
          IDX_TX1:      if (WSTRB[0]) next_q.tx1 = WDATA[7:0];
          IDX_TX2:      if (WSTRB[0]) next_q.tx2 = WDATA[7:0];
          IDX_UP1:      if (WSTRB[0]) next_q.up1 = WDATA[7:0];
          IDX_UP2:      if (WSTRB[0]) next_q.up2 = WDATA[7:0];
          IDX_DN1:      if (WSTRB[0]) next_q.dn1 = WDATA[7:0];
          IDX_DN2:      if (WSTRB[0]) next_q.dn2 = WDATA[7:0];
          IDX_CTL:
            if (WSTRB[0])
            begin
              next_q.tx_en   = WDATA[CTL_TX_EN];
              next_q.auto_rlb_detected_en = WDATA[CTL_AUTO_RLB_DETECTED];
            end
          IDX_INT_EN:   if (WSTRB[0]) next_q.int_en = WDATA[2:0];
          IDX_INT_CLR:  if (WSTRB[0]) clr = WDATA[2:0];
          IDX_RX_INFO, IDX_STATUS: ;
          default:      next_q.bresp = RESP_SLVERR;
        endcase
      end
      BS_RESP:
        if (BREADY)
        begin
          next_q.bvalid = 1'b0;
          next_q.wst    = BS_IDLE;
        end
      default: next_q.wst = BS_IDLE;
    endcase

    case (q.rst)
      BS_IDLE:
        if (ARVALID)
        begin
          next_q.arready = 1'b1;
          next_q.rst     = BS_ACK;
        end
      BS_ACK:
      begin
        next_q.arready = 1'b0;
        next_q.rvalid  = 1'b1;
        next_q.rresp   = RESP_OKAY;
        next_q.rst     = BS_RESP;
        next_q.rdata   = 32'h0;
        case (ridx)
          IDX_RX_INFO:
          begin
            next_q.rdata[7:0] = {q.level, 2'b00, q.auto_rlb_detected, q.sec_flag};
            sec_read = 1'b1;
          end
          IDX_CODE_CTL: next_q.rdata[7:0] = q.code_ctl;
          IDX_TX1:      next_q.rdata[7:0] = q.tx1;
          IDX_TX2:      next_q.rdata[7:0] = q.tx2;
          IDX_UP1:      next_q.rdata[7:0] = q.up1;
          IDX_UP2:      next_q.rdata[7:0] = q.up2;
          IDX_DN1:      next_q.rdata[7:0] = q.dn1;
          IDX_DN2:      next_q.rdata[7:0] = q.dn2;
          IDX_CTL:      next_q.rdata[1:0] = {q.auto_rlb_detected_en, q.tx_en};
          IDX_STATUS:   next_q.rdata[2:0] = q.status;
          IDX_INT_EN:   next_q.rdata[2:0] = q.int_en;
          IDX_INT_CLR:  ;
          default:      next_q.rresp = RESP_SLVERR;
        endcase
      end
      BS_RESP:
        if (RREADY)
        begin
          next_q.rvalid = 1'b0;
          next_q.rst    = BS_IDLE;
        end
      default: next_q.rst = BS_IDLE;
    endcase

    next_q.level = RX_LEVEL;

    // Receive side: one step per recovered line bit
    if (RX_BIT_VALID)
    begin
      next_q.hist = {q.hist[14:0], RX_BIT};
      up_hit = rot_match(next_q.hist, {q.up1, q.up2}, rx_len(q.code_ctl[UPLEN_LSB +: 3]));
      dn_hit = rot_match(next_q.hist, {q.dn1, q.dn2}, rx_len(q.code_ctl[DNLEN_LSB +: 3]));
      // A single bit error spoils at most 16 windows, far under the miss budget
      if (q.win_cnt >= INTEG_LEN - 1)
      begin
        next_q.up_present = (q.up_miss + {31'h0, ~up_hit}) < INTEG_LEN / MISS_DIV;
        next_q.dn_present = (q.dn_miss + {31'h0, ~dn_hit}) < INTEG_LEN / MISS_DIV;
        next_q.win_cnt    = 32'h0;
        next_q.up_miss    = 32'h0;
        next_q.dn_miss    = 32'h0;
      end
      else
      begin
        next_q.win_cnt = q.win_cnt + 32'h1;
        next_q.up_miss = q.up_miss + {31'h0, ~up_hit};
        next_q.dn_miss = q.dn_miss + {31'h0, ~dn_hit};
      end
      if (q.sec_cnt >= SEC_LEN - 1)
      begin
        next_q.sec_cnt = 32'h0;
        sec_tick = 1'b1;
      end
      else
        next_q.sec_cnt = q.sec_cnt + 32'h1;
    end

    if (sec_tick)
    begin
      next_q.up_secs = !q.up_present ? 3'h0 : (q.up_secs == HOLD_SEC) ? HOLD_SEC : q.up_secs + 3'h1;
      next_q.dn_secs = !q.dn_present ? 3'h0 : (q.dn_secs == HOLD_SEC) ? HOLD_SEC : q.dn_secs + 3'h1;
    end
    if (q.up_secs == HOLD_SEC)
      next_q.auto_rlb_detected = 1'b1;
    if (q.dn_secs == HOLD_SEC)
      next_q.auto_rlb_detected = 1'b0;
    if (!q.auto_rlb_detected_en)
      next_q.auto_rlb_detected = 1'b0;

    // Flag set beats a read in the same cycle
    next_q.sec_flag = sec_tick | (q.sec_flag & ~sec_read);

    set[ST_UP]  = q.up_present;
    set[ST_DN]  = q.dn_present;
    set[ST_SEC] = sec_tick;
    next_q.status = (q.status & ~clr) | set;
    next_q.irq    = |(next_q.status & next_q.int_en);

    // Transmit side: one step per requested line bit
    if (TX_BIT_REQ)
    begin
      if (q.tx_en)
      begin
        next_q.tx_data  = tx_code[4'hf - q.tx_phase];
        next_q.tx_phase = ({1'b0, q.tx_phase} >= tx_len - 5'h1) ? 4'h0 : q.tx_phase + 4'h1;
      end
      else
      begin
        next_q.tx_data  = 1'b0;
        next_q.tx_phase = 4'h0;
      end
    end
  end

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      q <= STATE_RST;
    else
      q <= next_q;
  end

  assign AWREADY         = q.awready;
  assign WREADY          = q.wready;
  assign BVALID          = q.bvalid;
  assign BRESP           = q.bresp;
  assign ARREADY         = q.arready;
  assign RVALID          = q.rvalid;
  assign RRESP           = q.rresp;
  assign RDATA           = q.rdata;
  assign TX_BIT          = q.tx_data;
  assign REMOTE_LOOPBACK = q.auto_rlb_detected;
  assign IRQ             = q.irq;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);

  sequence s_rx_info_read;
    q.rst == BS_ACK && ridx == IDX_RX_INFO;
  endsequence
  sequence s_no_tick;
    !sec_tick;
  endsequence
  sequence s_wr_taken;
    AWVALID && AWREADY && WVALID && WREADY;
  endsequence

  AST_LEVEL_FOLLOWS: assert property (s_rx_info_read |=> RDATA[7:4] == $past(q.level) && RDATA[3:2] == 2'b00)
    else $error("level nibble wrong");
  AST_AUTO_RLB_DETECTED_OFF: assert property (!q.auto_rlb_detected_en |=> !REMOTE_LOOPBACK)
    else $error("loopback flag set while disabled");
  AST_AUTO_RLB_DETECTED_RISE: assert property ($rose(REMOTE_LOOPBACK) |-> $past(q.up_secs) == HOLD_SEC)
    else $error("loopback flag rose early");
  AST_AUTO_RLB_DETECTED_FALL: assert property ($fell(REMOTE_LOOPBACK) && $past(q.auto_rlb_detected_en) |-> $past(q.dn_secs) == HOLD_SEC)
    else $error("loopback flag fell early");
  AST_SEC_SET: assert property (sec_tick |=> q.sec_flag ##1 q.sec_flag || $past(sec_read))
    else $error("second flag not latched");
  AST_SEC_CLR: assert property (s_rx_info_read ##0 s_no_tick |=> !q.sec_flag)
    else $error("second flag not cleared by read");
  AST_TX_OFF: assert property (TX_BIT_REQ && !q.tx_en |=> !TX_BIT)
    else $error("code sent while disabled");
  AST_TX_FIRST: assert property (TX_BIT_REQ && q.tx_en && q.tx_phase == 4'h0 |=> TX_BIT == $past(q.tx1[7]))
    else $error("pattern does not start with first MSB");
  AST_UP_STATUS: assert property ($rose(q.up_present) |=> q.status[ST_UP] [*2])
    else $error("loop-up status not latched");
  AST_WR_RESP: assert property (s_wr_taken |=> BVALID ##0 !AWREADY)
    else $error("write not answered");

endmodule : inband_loop_code_diag
`default_nettype wire

// >>> loop_line_model.sv
// Far-end line equipment sending a repeating loop code
`timescale 1ns/1ps
`default_nettype none
module loop_line_model (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic [15:0] pat,
  input  wire logic [4:0]  len,
  input  wire logic        slow,
  input  wire logic [6:0]  err_gap,
  output var  logic        rx_bit_valid,
  output var  logic        rx_bit
);
  logic [3:0] pos;
  logic [6:0] cnt;
  logic       tick;
  logic       step;
  assign step = !slow || tick;
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pos <= 4'h0;
      cnt <= 7'h00;
      tick <= 1'b0;
      rx_bit_valid <= 1'b0;
      rx_bit <= 1'b0;
    end
    else
    begin
      tick <= ~tick;
      rx_bit_valid <= step;
      if (step)
      begin
        pos <= ({1'b0, pos} + 5'h01 == len) ? 4'h0 : pos + 4'h1;
        cnt <= (cnt == err_gap) ? 7'h00 : cnt + 7'h01;
        // One flipped bit every err_gap+1 bits
        rx_bit <= pat[4'hf - pos] ^ (err_gap != 7'h00 && cnt == err_gap);
      end
    end
  end
endmodule : loop_line_model
`default_nettype wire

// >>> inband_loop_code_diag_tb.sv
// Self-checking bench of the in-band loop code block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin fails++; $display("mismatch %s exp %h got %h", n, e, s); end end
module inband_loop_code_diag_tb;
  import loop_code_pkg::*;
  logic        clk = 0, reset_n = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        tx_bit_req = 0, slow = 0;
  logic [7:0]  awaddr = 0, araddr = 0, rd;
  logic [31:0] wdata = 0, rdata;
  logic [3:0]  wstrb = 4'hf, rx_level = 4'h5;
  logic        awready, wready, bvalid, arready, rvalid, tx_bit, remote_loopback, irq, rxv, rxb;
  logic [1:0]  bresp, rresp, rs, bs;
  logic [15:0] pat = 16'h8000;
  logic [4:0]  len = 5'd5;
  int          fails = 0, checked = 0;
  int          lens[4] = '{5, 6, 7, 16};
  always #5 clk = ~clk;
  // A 16-bit code with one error per 100 bits spoils up to 48 of 256 windows, under the 64 budget
  inband_loop_code_diag #(.INTEG_LEN(256), .SEC_LEN(256)) inband_loop_code_diag_inst (
    .CLK(clk), .RESET_N(reset_n), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
    .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid),
    .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata),
    .RRESP(rresp), .RVALID(rvalid), .RREADY(rready), .RX_BIT_VALID(rxv), .RX_BIT(rxb),
    .RX_LEVEL(rx_level), .TX_BIT_REQ(tx_bit_req), .TX_BIT(tx_bit), .REMOTE_LOOPBACK(remote_loopback), .IRQ(irq));
  loop_line_model loop_line_model_inst (.clk(clk), .reset_n(reset_n), .pat(pat), .len(len),
    .slow(slow), .err_gap(7'd99), .rx_bit_valid(rxv), .rx_bit(rxb));
  task automatic wr(input logic [5:0] i, input logic [7:0] d);
    logic a, w;
    a = 0;
    w = 0;
    @(posedge clk);
    awaddr <= {i, 2'b00};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(a && w))
    begin
      @(posedge clk);
      if (awready) begin a = 1; awvalid <= 1'b0; end
      if (wready) begin w = 1; wvalid <= 1'b0; end
    end
    while (!bvalid) @(posedge clk);
    bs = bresp;
    bready <= 1'b0;
  endtask : wr
  task automatic rdr(input logic [5:0] i);
    @(posedge clk);
    araddr <= {i, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge clk);
    rd = rdata[7:0];
    rs = rresp;
    rready <= 1'b0;
  endtask : rdr
  task automatic summarize;
    $display("compares %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : summarize
  initial
  begin
    #300000;
    fails++;
    summarize;
  end
  initial
  begin
    logic [15:0] txp;
    txp = 16'hb65c;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    rdr(IDX_CODE_CTL);
    `CHK("code_ctl", 8'h00, rd)
    rdr(IDX_RX_INFO);
    `CHK("level", 4'h5, rd[7:4])
    rdr(6'h3f);
    `CHK("unmapped resp", RESP_SLVERR, rs)
    `CHK("unmapped data", 8'h00, rd)
    wr(6'h3f, 8'h5a);
    `CHK("unmapped write resp", RESP_SLVERR, bs)
    $display("test registers done");
    wr(IDX_TX1, txp[15:8]);
    wr(IDX_TX2, txp[7:0]);
    `CHK("write resp", RESP_OKAY, bs)
    for (int k = 0; k < 4; k++)
    begin
      wr(IDX_CODE_CTL, {k[1:0], 6'h27});
      wr(IDX_CTL, 8'h01);
      tx_bit_req <= 1'b1;
      // Two full repetitions, requests back to back
      for (int j = 1; j <= 2 * lens[k] + 1; j++)
      begin
        @(posedge clk);
        if (j >= 2) `CHK("tx bit", txp[15 - (j - 2) % lens[k]], tx_bit)
        if (j == 2 * lens[k]) tx_bit_req <= 1'b0;
      end
      wr(IDX_CTL, 8'h00);
      tx_bit_req <= 1'b1;
      @(posedge clk);
      tx_bit_req <= 1'b0;
      @(posedge clk);
      `CHK("tx off", 1'b0, tx_bit)
    end
    $display("test transmit done");
    wr(IDX_UP1, 8'h80);
    wr(IDX_DN1, 8'hf0);
    wr(IDX_DN2, 8'h0f);
    wr(IDX_INT_EN, 8'h01);
    wr(IDX_CTL, 8'h02);
    wr(IDX_INT_CLR, 8'h07);
    rx_level <= 4'ha;
    // Two windows to detect, then five seconds, with margin
    repeat (8 * 256) @(posedge clk);
    rdr(IDX_STATUS);
    `CHK("up status", 2'b01, rd[1:0])
    `CHK("irq up", 1'b1, irq)
    `CHK("loopback on", 1'b1, remote_loopback)
    rdr(IDX_RX_INFO);
    `CHK("info", 8'ha3, rd & 8'hf3)
    rdr(IDX_RX_INFO);
    `CHK("second cleared", 1'b0, rd[0])
    $display("test loop up done");
    pat <= 16'hf00f;
    len <= 5'd16;
    slow <= 1'b1;
    // Half-rate bits: eight seconds of down code
    repeat (16 * 256) @(posedge clk);
    wr(IDX_INT_CLR, 8'h07);
    rdr(IDX_STATUS);
    `CHK("down status", 2'b10, rd[1:0])
    `CHK("irq masked", 1'b0, irq)
    `CHK("loopback off", 1'b0, remote_loopback)
    wr(IDX_INT_EN, 8'h02);
    repeat (3) @(posedge clk);
    `CHK("irq down", 1'b1, irq)
    $display("test loop down done");
    pat <= 16'h8000;
    len <= 5'd5;
    slow <= 1'b0;
    repeat (8 * 256) @(posedge clk);
    `CHK("loopback again", 1'b1, remote_loopback)
    wr(IDX_CTL, 8'h00);
    repeat (2) @(posedge clk);
    `CHK("loopback disabled", 1'b0, remote_loopback)
    rdr(IDX_RX_INFO);
    `CHK("info disabled", 1'b0, rd[1])
    $display("test auto disable done");
    summarize;
  end
endmodule : inband_loop_code_diag_tb
`default_nettype wire
